// ---- core/ppo_ms_tick.sv ----
`timescale 1ns/10ps
// =============================================================
// Free-running millisecond tick
// =============================================================
module ppo_ms_tick #(
   parameter int unsigned CYCLES = 250000
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   output logic tick
);
   logic [31:0] cnt;
   wire last = (cnt == 32'(CYCLES - 1));

   // Counter wraps every CYCLES enabled clocks, tick marks the wrap
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else if (ce) begin
         cnt <= last ? 32'h0 : cnt + 32'h1;
         tick <= last;
      end
   end
endmodule // ppo_ms_tick

// ---- core/ppo_top.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Modulated high time takes 0 to 3000 ms
// - Period 1 to 3000 ms, width above period errs
// - Each function drives only channel 0 or 1
// - Modulated edges timed by hardware, not scan
// - Modulated drive low forces its channel low
// - Ramp maximum 10 to 100000 Hz, 10 Hz steps
// - Deceleration step is a tenth of maximum, at least 10 Hz
// - Count 110..32767 short, 110..2147483647 wide; counts below 110 are not refused
// - Wide count: low word then high word
// - One ramp time below 5000 ms, both ramps
// - Frequencies outside range are clamped into it
// - Drive drop aborts, reassert restarts from zero
// - Parameter changes apply at next drive only
// - Finished pulse count sets the done flag
// - Linear ramp up, linear down, exact count
// - Ramp timing by hardware, not by scan
module ppo_top
   import ppo_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = PPO_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pwm_drive_input,
   input wire logic ramp_drive_input,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pulse_out_0,
   output logic pulse_out_1,
   output logic pulse_done_flag
);
   // =============================================================
   // Drive pin synchronisers
   // =============================================================
   wire [1:0] drv_pin = {ramp_drive_input, pwm_drive_input};
   logic [1:0] drv_meta;
   logic [1:0] drv_sync;
   logic [1:0] drv_prev;

   // Two flops per pin, edge detect only after the second
   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            drv_meta[i] <= 1'b0;
            drv_sync[i] <= 1'b0;
            drv_prev[i] <= 1'b0;
         end else if (ce) begin
            drv_meta[i] <= drv_pin[i];
            drv_sync[i] <= drv_meta[i];
            drv_prev[i] <= drv_sync[i];
         end
      end
   end

   wire pwm_rise = drv_sync[0] & ~drv_prev[0];
   wire ramp_rise = drv_sync[1] & ~drv_prev[1];
   wire ramp_fall = ~drv_sync[1] & drv_prev[1];
   // =============================================================
   // Millisecond time base
   // =============================================================
   logic ms_tick;

   ppo_ms_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(ms_tick)
   );
   // =============================================================
   // APB slave
   // =============================================================
   logic [2:0] ctrl;
   logic [11:0] width;
   logic [11:0] period;
   logic [16:0] freq;
   logic [15:0] cnt_lo;
   logic [15:0] cnt_hi;
   logic [12:0] ramp_ms;
   logic p_err;
   ppo_ramp_state_t r_state;
   logic [30:0] r_emitted;

   wire access = psel & penable & pready;
   wire wr_en = access & pwrite;
   wire hit_ctrl = (paddr == PPO_OFS_CTRL);
   wire hit_width = (paddr == PPO_OFS_WIDTH);
   wire hit_period = (paddr == PPO_OFS_PERIOD);
   wire hit_freq = (paddr == PPO_OFS_FREQ);
   wire hit_lo = (paddr == PPO_OFS_CNT_LO);
   wire hit_hi = (paddr == PPO_OFS_CNT_HI);
   wire hit_ramp = (paddr == PPO_OFS_RAMP_MS);
   wire hit_status = (paddr == PPO_OFS_STATUS);
   wire hit_emit = (paddr == PPO_OFS_EMITTED);
   wire hit_any = hit_ctrl | hit_width | hit_period | hit_freq | hit_lo | hit_hi
      | hit_ramp | hit_status | hit_emit;
   wire ramp_busy = (r_state != PPO_R_IDLE) && (r_state != PPO_R_DONE);
   wire [31:0] status_word = {29'h0, ramp_busy, p_err, pulse_done_flag};

   // Read selection; unmapped offsets read zero with an error
   wire [31:0] rd_data =
      hit_ctrl ? {29'h0, ctrl} :
      hit_width ? {20'h0, width} :
      hit_period ? {20'h0, period} :
      hit_freq ? {15'h0, freq} :
      hit_lo ? {16'h0, cnt_lo} :
      hit_hi ? {16'h0, cnt_hi} :
      hit_ramp ? {19'h0, ramp_ms} :
      hit_status ? status_word :
      hit_emit ? {1'b0, r_emitted} : 32'h0;

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h0;
         pslverr <= psel & penable & ~pready & ~hit_any;
      end
   end

   // Configuration registers; shadows only, latched at drive edges
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= PPO_CTRL_RST;
         width <= PPO_WIDTH_RST;
         period <= PPO_PERIOD_RST;
         freq <= PPO_FREQ_RST;
         cnt_lo <= PPO_CNT_RST;
         cnt_hi <= 16'h0;
         ramp_ms <= PPO_RAMP_MS_RST;
      end else if (ce && wr_en) begin
         if (hit_ctrl) ctrl <= pwdata[2:0];
         if (hit_width) width <= pwdata[11:0];
         if (hit_period) period <= pwdata[11:0];
         if (hit_freq) freq <= pwdata[16:0];
         if (hit_lo) cnt_lo <= pwdata[15:0];
         if (hit_hi) cnt_hi <= pwdata[15:0];
         if (hit_ramp) ramp_ms <= pwdata[12:0];
      end
   end
   // =============================================================
   // Modulated output
   // =============================================================
   logic p_ch;
   logic [11:0] p_width;
   logic [11:0] p_period;
   logic [11:0] p_cnt;
   wire p_bad = (width > period) || (period == 12'h0) || (period > PPO_PERIOD_MAX)
      || (width > PPO_WIDTH_MAX);
   wire p_wrap = (p_cnt + 12'h1 == p_period);
   // High from period start until width; masked in the edge cycle, settings still stale
   wire pwm_hi = drv_sync[0] & drv_prev[0] & ~p_err & (p_cnt < p_width);

   // Counter advances only on the tick, so scan timing never enters
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         p_ch <= 1'b0;
         p_width <= 12'h0;
         p_period <= 12'h1;
         p_cnt <= 12'h0;
         p_err <= 1'b0;
      end else if (ce) begin
         if (pwm_rise) begin
            p_ch <= ctrl[PPO_CTRL_PWM_CH];
            p_width <= width;
            p_period <= period;
            p_err <= p_bad;
            p_cnt <= 12'h0;
         end else if (drv_sync[0] && ms_tick) begin
            p_cnt <= p_wrap ? 12'h0 : p_cnt + 12'h1;
         end
      end
   end
   // =============================================================
   // Ramp parameter conditioning
   // =============================================================
   wire [16:0] f_clamp = (freq < PPO_FREQ_MIN) ? PPO_FREQ_MIN :
      (freq > PPO_FREQ_MAX) ? PPO_FREQ_MAX : freq;
   wire [16:0] f_units = f_clamp / PPO_FREQ_RES;
   wire [16:0] f_max = 17'(f_units * PPO_FREQ_RES);
   wire [16:0] f_tenth = f_max / PPO_RAMP_DIV;
   wire [16:0] f_step = (f_tenth < PPO_FREQ_MIN) ? PPO_FREQ_MIN : f_tenth;
   wire [12:0] t_clamp = (ramp_ms > PPO_RAMP_MS_MAX) ? PPO_RAMP_MS_MAX : ramp_ms;
   wire [12:0] t_div = t_clamp / PPO_RAMP_STEPS;
   wire [12:0] t_step = (t_div == 13'h0) ? 13'h1 : t_div;
   // Wide form joins both words, low word first; sign bit ignored
   wire [30:0] total_req = ctrl[PPO_CTRL_WIDE] ? {cnt_hi[14:0], cnt_lo} :
      {16'h0, cnt_lo[14:0]};
   // =============================================================
   // Ramped pulse train
   // =============================================================
   logic r_ch;
   logic [16:0] r_fmax;
   logic [16:0] r_fstep;
   logic [12:0] r_tstep;
   logic [30:0] r_total;
   logic [30:0] r_ramp_pulses;
   logic [12:0] r_timer;
   logic [16:0] r_cur;
   logic [26:0] r_acc;
   logic r_wave;

   wire running = ramp_busy;
   wire [26:0] acc_sum = r_acc + {10'h0, r_cur};
   wire half_done = running && (acc_sum >= PPO_HALF_RATE);
   wire pulse_end = half_done && r_wave;
   wire [30:0] emit_next = r_emitted + 31'h1;
   wire last_pulse = pulse_end && (emit_next == r_total);
   wire step_due = ms_tick && (r_timer + 13'h1 >= r_tstep);
   wire [17:0] up_sum = {1'b0, r_cur} + {1'b0, r_fstep};
   wire up_top = (up_sum >= {1'b0, r_fmax});
   wire dn_floor = (r_cur <= {r_fstep[15:0], 1'b0}) || (r_cur <= r_fstep);
   wire [30:0] remain = r_total - r_emitted;
   // Deceleration begins once what is left matches the ramp-up cost
   wire go_decel = (r_state == PPO_R_ACCEL) ? ({r_emitted[29:0], 1'b0} >= r_total) :
      (remain <= r_ramp_pulses);

   // Profile sequencer; settings are sampled only at the drive edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         r_state <= PPO_R_IDLE;
         r_ch <= 1'b0;
         r_fmax <= PPO_FREQ_MIN;
         r_fstep <= PPO_FREQ_MIN;
         r_tstep <= 13'h1;
         r_total <= 31'h0;
         r_ramp_pulses <= 31'h0;
         r_timer <= 13'h0;
         r_cur <= 17'h0;
         r_acc <= 27'h0;
         r_wave <= 1'b0;
         r_emitted <= 31'h0;
      end else if (ce) begin
         if (ramp_fall) begin
            r_state <= PPO_R_IDLE;
            r_wave <= 1'b0;
            r_cur <= 17'h0;
         end else if (ramp_rise) begin
            r_ch <= ctrl[PPO_CTRL_RAMP_CH];
            r_fmax <= f_max;
            r_fstep <= f_step;
            r_tstep <= t_step;
            r_total <= total_req;
            r_cur <= f_step;
            r_emitted <= 31'h0;
            r_acc <= 27'h0;
            r_timer <= 13'h0;
            r_wave <= 1'b0;
            r_ramp_pulses <= 31'h0;
            // A zero count has nothing to emit; below 110 is not refused
            r_state <= (total_req == 31'h0) ? PPO_R_DONE : PPO_R_ACCEL;
         end else if (running) begin
            r_acc <= half_done ? acc_sum - PPO_HALF_RATE : acc_sum;
            if (half_done) r_wave <= ~r_wave;
            if (pulse_end) r_emitted <= emit_next;
            if (ms_tick) r_timer <= step_due ? 13'h0 : r_timer + 13'h1;
            if (last_pulse) begin
               r_state <= PPO_R_DONE;
               r_cur <= 17'h0;
            end else begin
               unique case (r_state)
                  PPO_R_ACCEL: begin
                     if (go_decel) begin
                        r_ramp_pulses <= r_emitted;
                        r_state <= PPO_R_DECEL;
                     end else if (step_due) begin
                        r_cur <= up_top ? r_fmax : up_sum[16:0];
                        if (up_top) begin
                           r_ramp_pulses <= r_emitted;
                           r_state <= PPO_R_CRUISE;
                        end
                     end
                  end
                  PPO_R_CRUISE: begin
                     if (go_decel) r_state <= PPO_R_DECEL;
                  end
                  PPO_R_DECEL: begin
                     if (step_due) r_cur <= dn_floor ? r_fstep : r_cur - r_fstep;
                  end
                  PPO_R_IDLE, PPO_R_DONE: r_cur <= r_cur;
               endcase
            end
         end
      end
   end
   // =============================================================
   // Done flag and output channels
   // =============================================================
   wire done_clr = wr_en & hit_status & pwdata[PPO_ST_DONE];
   wire ramp_hi = running & r_wave;

   // Completion beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pulse_done_flag <= 1'b0;
      end else if (ce) begin
         if (last_pulse || (ramp_rise && total_req == 31'h0)) begin
            pulse_done_flag <= 1'b1;
         end else if (done_clr || ramp_rise) begin
            pulse_done_flag <= 1'b0;
         end
      end
   end

   // Each function reaches only its latched channel; a shared
   // channel simply ORs both, which software must avoid
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pulse_out_0 <= 1'b0;
         pulse_out_1 <= 1'b0;
      end else if (ce) begin
         pulse_out_0 <= (pwm_hi & ~p_ch) | (ramp_hi & ~r_ch);
         pulse_out_1 <= (pwm_hi & p_ch) | (ramp_hi & r_ch);
      end
   end
endmodule // ppo_top

// ---- pkg/ppo_pkg.sv ----
// =============================================================
// Constants for the modulated and ramped pulse outputs
// =============================================================
package ppo_pkg;

   // =============================================================
   // Clock and time base
   // =============================================================
   localparam int unsigned PPO_CLK_PERIOD_NS = 4;
   localparam int unsigned PPO_MS_NS = 1000000;
   localparam int unsigned PPO_TICK_CYCLES = PPO_MS_NS / PPO_CLK_PERIOD_NS;
   // Accumulator wrap for one half wave at one hertz
   localparam logic [26:0] PPO_HALF_RATE = 27'(1000000000 / PPO_CLK_PERIOD_NS / 2);

   // =============================================================
   // Register byte offsets
   // =============================================================
   localparam logic [7:0] PPO_OFS_CTRL = 8'h00;
   localparam logic [7:0] PPO_OFS_WIDTH = 8'h04;
   localparam logic [7:0] PPO_OFS_PERIOD = 8'h08;
   localparam logic [7:0] PPO_OFS_FREQ = 8'h0c;
   localparam logic [7:0] PPO_OFS_CNT_LO = 8'h10;
   localparam logic [7:0] PPO_OFS_CNT_HI = 8'h14;
   localparam logic [7:0] PPO_OFS_RAMP_MS = 8'h18;
   localparam logic [7:0] PPO_OFS_STATUS = 8'h1c;
   localparam logic [7:0] PPO_OFS_EMITTED = 8'h20;

   // =============================================================
   // Field positions
   // =============================================================
   localparam int unsigned PPO_CTRL_PWM_CH = 0;
   localparam int unsigned PPO_CTRL_RAMP_CH = 1;
   localparam int unsigned PPO_CTRL_WIDE = 2;
   localparam int unsigned PPO_ST_DONE = 0;
   localparam int unsigned PPO_ST_PWM_ERR = 1;
   localparam int unsigned PPO_ST_RAMP_BUSY = 2;

   // =============================================================
   // Limits and reset values
   // =============================================================
   localparam logic [11:0] PPO_WIDTH_MAX = 12'hbb8;
   localparam logic [11:0] PPO_PERIOD_MAX = 12'hbb8;
   localparam logic [16:0] PPO_FREQ_MIN = 17'h0000a;
   localparam logic [16:0] PPO_FREQ_MAX = 17'h186a0;
   localparam logic [16:0] PPO_FREQ_RES = 17'h0000a;
   localparam logic [16:0] PPO_RAMP_DIV = 17'h0000a;
   localparam logic [12:0] PPO_RAMP_MS_MAX = 13'h1387;
   localparam logic [12:0] PPO_RAMP_STEPS = 13'h000a;
   localparam logic [2:0] PPO_CTRL_RST = 3'h0;
   localparam logic [11:0] PPO_WIDTH_RST = 12'h000;
   localparam logic [11:0] PPO_PERIOD_RST = 12'h001;
   localparam logic [16:0] PPO_FREQ_RST = 17'h0000a;
   localparam logic [15:0] PPO_CNT_RST = 16'h006e;
   localparam logic [12:0] PPO_RAMP_MS_RST = 13'h0064;

   typedef enum logic [2:0] {
      PPO_R_IDLE,
      PPO_R_ACCEL,
      PPO_R_CRUISE,
      PPO_R_DECEL,
      PPO_R_DONE
   } ppo_ramp_state_t;

endpackage

// ---- verif/ppo_checker.sv ----
`timescale 1ns/10ps
// =============================================================
// Port checker for the pulse output block
// =============================================================
module ppo_checker
   import ppo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pwm_drive_input,
   input wire logic ramp_drive_input,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_out_0,
   input wire logic pulse_out_1,
   input wire logic pulse_done_flag
);
   logic [3:0] quiet;
   logic [3:0] rquiet;
   // Status clear request, and a plain aligned access
   wire logic done_clr = psel && penable && pready && pwrite
      && paddr == PPO_OFS_STATUS && pwdata[0];
   wire logic aligned = paddr[1:0] == 2'h0;

   // Cycles since any drive pin was high, saturating
   always_ff @(posedge ref_clk) begin
      if (!rst_n || pwm_drive_input || ramp_drive_input) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end

   // Cycles since the ramp drive pin was high, saturating
   always_ff @(posedge ref_clk) begin
      if (!rst_n || ramp_drive_input) rquiet <= 4'h0;
      else if (rquiet != 4'hf) rquiet <= rquiet + 4'h1;
   end

   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Bus answers in the second access cycle, for one cycle only
   AST_SETUP_ANSWER: assert property ((psel && !penable) |=> !pready ##1 pready)
      else $error("bus answer not in second access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_IDLE_DATA_ZERO: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero outside answer");
   AST_ERR_QUALIFIED: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer without ready or with data");
   AST_MAP_DECODE: assert property ((pready && aligned) |-> pslverr == (paddr > PPO_OFS_EMITTED))
      else $error("address decode error flag wrong");
   // Pin sync costs a few edges, so six quiet cycles are allowed first
   AST_DRIVE_OFF_LOW: assert property ((quiet > 4'h5) |-> !(pulse_out_0 || pulse_out_1))
      else $error("channel active with both drives off");
   AST_DONE_NEEDS_DRIVE: assert property ($rose(pulse_done_flag) |-> rquiet < 4'h8)
      else $error("done raised with ramp drive off");
   AST_DONE_CLEAR: assert property ((done_clr && rquiet > 4'h7) |=> !pulse_done_flag)
      else $error("done not cleared by status write");
endmodule // ppo_checker

// ---- verif/ppo_load_model.sv ----
`timescale 1ns/10ps
// =============================================================
// Load on one transistor channel: counts and times pulses
// =============================================================
module ppo_load_model (
   input wire logic ref_clk,
   input wire logic line,
   output int unsigned edges,
   output int unsigned hi_len,
   output int unsigned per_len
);
   int unsigned since = 0;
   logic last = 1'b0;
   // Passive input stage: it listens and never loads the line back
   initial begin
      edges = 0;
      hi_len = 0;
      per_len = 0;
   end
   // Time each high phase and each rise-to-rise span in clocks
   always @(posedge ref_clk) begin
      if (line && !last) begin
         edges = edges + 1;
         per_len = since;
         since = 0;
      end
      if (!line && last) hi_len = since;
      since = since + 1;
      last = line;
   end
endmodule // ppo_load_model

// ---- verif/ppo_top_test.sv ----
`timescale 1ns/10ps
// =============================================================
// Bench for the pulse output block
// =============================================================
module ppo_top_test import ppo_pkg::*;;
   // Short millisecond so one ms is ten clocks
   localparam int unsigned TCK = 10;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic pwm_drive_input = 1'b0;
   logic ramp_drive_input = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pulse_out_0;
   logic pulse_out_1;
   logic pulse_done_flag;
   logic [31:0] rdv;
   logic errv;
   int bad_count = 0;
   int n_compared = 0;
   int unsigned e0, e1, h0, h1, p0, p1, b;
   logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'h1, 32'ha, 32'h6e, 32'h0, 32'h64, 32'h0, 32'h0};
   logic [31:0] wtab [4] = '{32'h6, 32'hbb9, 32'h0, 32'h0};
   logic [31:0] ptab [4] = '{32'h5, 32'hbb9, 32'h0, 32'h5};

   ppo_top #(.TICK_CYCLES(TCK)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .pwm_drive_input(pwm_drive_input), .ramp_drive_input(ramp_drive_input),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out_0(pulse_out_0),
      .pulse_out_1(pulse_out_1), .pulse_done_flag(pulse_done_flag));
   ppo_load_model load0_u (.ref_clk(ref_clk), .line(pulse_out_0), .edges(e0),
      .hi_len(h0), .per_len(p0));
   ppo_load_model load1_u (.ref_clk(ref_clk), .line(pulse_out_1), .edges(e1),
      .hi_len(h1), .per_len(p1));

   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;

   // One bus transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      // A bus that never answers counts against the run
      if (pready !== 1'b1) bad_count++;
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Bounded wait: the slowest pulse of a short train is well inside it
   task automatic wait_done();
      int n;
      n = 0;
      while (pulse_done_flag !== 1'b1 && n < 40000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog sized above the longest expected run
   initial begin
      repeat (98000) @(posedge ref_clk);
      bad_count++;
      close_out();
   end

   // =============================================================
   // Test sequence
   // =============================================================
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rdv, rst_tab[i]);
         check({31'h0, errv}, 32'h0);
      end
      apb(1'b0, 8'h24, 32'h0);
      check({31'h0, errv}, 32'h1);
      apb(1'b1, PPO_OFS_EMITTED, 32'hffffffff);
      apb(1'b0, PPO_OFS_EMITTED, 32'h0);
      check(rdv, 32'h0);
      apb(1'b1, PPO_OFS_CNT_LO, 32'hffffffff);
      apb(1'b0, PPO_OFS_CNT_LO, 32'h0);
      check(rdv, 32'h0000ffff);
      // Modulated output on each channel in turn
      for (int ch = 0; ch < 2; ch++) begin
         apb(1'b1, PPO_OFS_CTRL, 32'(ch));
         apb(1'b1, PPO_OFS_WIDTH, 32'h2);
         apb(1'b1, PPO_OFS_PERIOD, 32'h5);
         b = ch ? e0 : e1;
         pwm_drive_input <= 1'b1;
         cyc(14 * TCK);
         check(ch ? h1 : h0, 32'(2 * TCK));
         check(ch ? p1 : p0, 32'(5 * TCK));
         check(ch ? e0 : e1, b);
         pwm_drive_input <= 1'b0;
         cyc(8);
         check({31'h0, ch ? pulse_out_1 : pulse_out_0}, 32'h0);
      end
      // Bad settings flag an error; zero width stays low
      apb(1'b1, PPO_OFS_CTRL, 32'h0);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, PPO_OFS_WIDTH, wtab[k]);
         apb(1'b1, PPO_OFS_PERIOD, ptab[k]);
         b = e0;
         pwm_drive_input <= 1'b1;
         cyc(8 * TCK);
         apb(1'b0, PPO_OFS_STATUS, 32'h0);
         if (k < 3) check({31'h0, rdv[PPO_ST_PWM_ERR]}, 32'h1);
         else check({31'h0, rdv[PPO_ST_PWM_ERR]}, 32'h0);
         check(e0, b);
         pwm_drive_input <= 1'b0;
         cyc(8);
      end
      // Short train; count kept small so the run stays short
      apb(1'b1, PPO_OFS_FREQ, 32'h186a0);
      apb(1'b1, PPO_OFS_CNT_LO, 32'h2);
      apb(1'b1, PPO_OFS_CNT_HI, 32'h0);
      apb(1'b1, PPO_OFS_RAMP_MS, 32'ha);
      b = e0;
      ramp_drive_input <= 1'b1;
      wait_done();
      check({31'h0, pulse_done_flag}, 32'h1);
      check(e0 - b, 32'h2);
      apb(1'b0, PPO_OFS_EMITTED, 32'h0);
      check(rdv, 32'h2);
      ramp_drive_input <= 1'b0;
      cyc(12);
      apb(1'b1, PPO_OFS_STATUS, 32'h1);
      apb(1'b0, PPO_OFS_STATUS, 32'h0);
      check(rdv & 32'h1, 32'h0);
      // Wide count, channel rewrite in mid-run, then abort
      apb(1'b1, PPO_OFS_CTRL, 32'h4);
      apb(1'b1, PPO_OFS_CNT_HI, 32'h1);
      apb(1'b1, PPO_OFS_CNT_LO, 32'h0);
      b = e1;
      ramp_drive_input <= 1'b1;
      cyc(8000);
      apb(1'b1, PPO_OFS_CTRL, 32'h6);
      cyc(4000);
      check(e1, b);
      apb(1'b0, PPO_OFS_STATUS, 32'h0);
      check({31'h0, rdv[PPO_ST_RAMP_BUSY]}, 32'h1);
      ramp_drive_input <= 1'b0;
      cyc(8);
      check({31'h0, pulse_out_0}, 32'h0);
      apb(1'b0, PPO_OFS_STATUS, 32'h0);
      check({31'h0, rdv[PPO_ST_RAMP_BUSY]}, 32'h0);
      // Short form ignores the high word; restart counts from zero;
      // a slow ramp ends the first pulse in acceleration, so deceleration runs
      apb(1'b1, PPO_OFS_CTRL, 32'h0);
      apb(1'b1, PPO_OFS_CNT_LO, 32'h8002);
      apb(1'b1, PPO_OFS_RAMP_MS, 32'h3e8);
      b = e0;
      ramp_drive_input <= 1'b1;
      wait_done();
      check({31'h0, pulse_done_flag}, 32'h1);
      check(e0 - b, 32'h2);
      apb(1'b0, PPO_OFS_EMITTED, 32'h0);
      check(rdv, 32'h2);
      ramp_drive_input <= 1'b0;
      close_out();
   end
endmodule // ppo_top_test

bind ppo_top ppo_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
   .pwm_drive_input(pwm_drive_input), .ramp_drive_input(ramp_drive_input),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out_0(pulse_out_0),
   .pulse_out_1(pulse_out_1), .pulse_done_flag(pulse_done_flag));
